// [rtl/sps_i2c_host.sv]
// controller end: axi4-lite registers and a two-wire bus master
// assumes the device never stretches the clock
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`default_nettype none
module sps_i2c_host
  import sps_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  sps_i2c_if.host bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // device needs a few cycles of each phase for its synchroniser
  if (QTR < 6 || QTR > 255) begin : g_qtr_chk
    $error("QTR out of range");
  end

  typedef struct packed {
    logic [1:0] sda_s;
    sps_hst_e st;
    logic [2:0] step;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [7:0] qc;
    logic [7:0] sh;
    logic ackb;
    logic nack;
    logic [7:0] rdat8;
    logic scl_oe;
    logic sda_oe;
    logic rw;
    logic [6:0] dev;
    logic [15:0] ra;
    logic [7:0] wd;
    logic aw_h;
    logic w_h;
    logic [7:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdat;
    logic [1:0] rresp;
  } sps_host_s;

  localparam sps_host_s HOST_RST = '0;

  sps_host_s q;
  sps_host_s n;
  sps_op_e op;
  sps_op_e nop;
  logic [31:0] ctrl_v;
  logic [31:0] stat_v;
  logic [31:0] mv;

  // write sequence S A RH RL D P, read S A RH RL Sr A' D P
  function automatic sps_op_e host_op(input logic rw, input logic [2:0] s);
    if (s == 3'h0 || (rw && s == 3'h4)) return OP_S;
    if ((!rw && s == 3'h5) || (rw && s == 3'h7)) return OP_P;
    if (rw && s == 3'h6) return OP_R;
    return OP_B;
  endfunction

  // byte merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = v[8*i +: 8];
    end
    return r;
  endfunction

  assign op = host_op(q.rw, q.step);
  assign ctrl_v = {17'h0, q.dev, 6'h0, q.rw, q.st == HS_RUN};
  assign stat_v = {16'h0, q.rdat8, 6'h0, q.nack, q.st == HS_RUN};

  // ==========================================================
  // next state
  always_comb begin
    n = q;
    nop = OP_S;
    mv = 32'h0;
    n.sda_s = {q.sda_s[0], bus.sda};
    // axi write: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_h = 1'b1;
      n.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_h = 1'b1;
      n.wdat = s_axi_wdata;
      n.wstb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_h && q.w_h) begin
      n.aw_h = 1'b0;
      n.w_h = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (q.waddr)
        HR_CTRL: begin
          mv = merge(ctrl_v, q.wdat, q.wstb);
          // go while busy is ignored so a running transfer is never restarted; raddr and wdata writes still land mid-transfer
          if (q.st == HS_IDLE) begin
            n.rw = mv[CTRL_RW];
            n.dev = mv[CTRL_DEV_LSB +: 7];
            if (mv[CTRL_GO] && q.wstb[0]) begin
              n.st = HS_RUN;
              n.step = 3'h0;
              n.ph = 2'h0;
              n.qc = 8'h0;
              n.bitn = 4'h0;
              n.nack = 1'b0;
            end
          end
        end
        HR_RADDR: begin
          mv = merge({16'h0, q.ra}, q.wdat, q.wstb);
          n.ra = mv[15:0];
        end
        HR_WDATA: begin
          mv = merge({24'h0, q.wd}, q.wdat, q.wstb);
          n.wd = mv[7:0];
        end
        HR_STAT: begin
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // axi read
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        HR_CTRL: n.rdat = ctrl_v;
        HR_RADDR: n.rdat = {16'h0, q.ra};
        HR_WDATA: n.rdat = {24'h0, q.wd};
        HR_STAT: n.rdat = stat_v;
        default: begin
          n.rdat = 32'h0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    // bus engine: four quarter phases per bit or condition
    if (q.st == HS_RUN) begin
      if (q.qc != 8'(QTR - 1)) begin
        n.qc = q.qc + 8'h01;
      end else begin
        n.qc = 8'h0;
        if (q.ph == 2'h1) begin
          // sample in the middle of the high clock
          if (op == OP_R && q.bitn != 4'h8) n.sh = {q.sh[6:0], q.sda_s[1]};
          if (op == OP_B && q.bitn == 4'h8) n.ackb = q.sda_s[1];
        end
        if (q.ph != 2'h3) begin
          n.ph = q.ph + 2'h1;
        end else begin
          n.ph = 2'h0;
          if ((op == OP_B || op == OP_R) && q.bitn != 4'h8) begin
            n.bitn = q.bitn + 4'h1;
            if (op == OP_B) n.sh = {q.sh[6:0], 1'b0};
          end else begin
            n.bitn = 4'h0;
            if (op == OP_R) n.rdat8 = q.sh;
            if (op == OP_P) begin
              n.st = HS_IDLE;
            end else if (op == OP_B && q.ackb) begin
              // nack from the device: go straight to stop
              n.nack = 1'b1;
              n.step = q.rw ? 3'h7 : 3'h5;
            end else begin
              n.step = q.step + 3'h1;
            end
            unique case (n.step)
              3'h1: n.sh = {q.dev, 1'b0};
              3'h2: n.sh = q.ra[15:8];
              3'h3: n.sh = q.ra[7:0];
              3'h4: n.sh = q.wd;
              3'h5: n.sh = {q.dev, 1'b1};
              default: n.sh = 8'h0;
            endcase
          end
        end
      end
    end
    // pin drive for the coming phase; clock low in phases 0 and 3, for stop in phase 0 only
    nop = host_op(n.rw, n.step);
    n.scl_oe = 1'b0;
    n.sda_oe = 1'b0;
    if (n.st == HS_RUN) begin
      unique case (nop)
        // start: data falls while clock high
        OP_S: begin
          n.scl_oe = (n.ph == 2'h0) || (n.ph == 2'h3);
          n.sda_oe = n.ph[1];
        end
        // stop: data rises while clock high
        OP_P: begin
          n.scl_oe = (n.ph == 2'h0);
          n.sda_oe = !n.ph[1];
        end
        OP_B: begin
          n.scl_oe = (n.ph == 2'h0) || (n.ph == 2'h3);
          n.sda_oe = (n.bitn != 4'h8) && !n.sh[7];
        end
        OP_R: begin
          // single byte read, ninth bit left high as nack
          n.scl_oe = (n.ph == 2'h0) || (n.ph == 2'h3);
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= HOST_RST;
    end else begin
      q <= n;
    end
  end

  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = q.scl_oe;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = q.sda_oe;
  assign s_axi_awready = !q.aw_h && !q.bvalid;
  assign s_axi_wready = !q.w_h && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdat;
  assign s_axi_rresp = q.rresp;
endmodule // sps_i2c_host
`default_nettype wire

// [rtl/sps_pkg.sv]
// shared constants and types for the serial port select block
// assumes both ends run on one 10 MHz mclk with a synchronous reset
`default_nettype none
package sps_pkg;
  // ==========================================================
  // timing
  localparam int MCLK_HZ = 10_000_000;
  localparam int SCL_HZ = 100_000;
  // quarter of an scl period in mclk cycles, rounded down
  localparam int SCL_QTR_CYC = MCLK_HZ / (4 * SCL_HZ);
  // ==========================================================
  // slave address and straps
  localparam logic [3:0] ADDR_FIXED = 4'hB;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [15:0] RELOAD_REG = 16'h0B02;
  localparam int RELOAD_BIT = 1;
  // ==========================================================
  // controller register map and fields
  localparam logic [7:0] HR_CTRL = 8'h00;
  localparam logic [7:0] HR_RADDR = 8'h04;
  localparam logic [7:0] HR_WDATA = 8'h08;
  localparam logic [7:0] HR_STAT = 8'h0C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RW = 1;
  localparam int CTRL_DEV_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_RD_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // state encodings
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_RX = 3'h1, DS_ACK = 3'h2, DS_TX = 3'h3, DS_RACK = 3'h4
  } sps_dst_e;
  typedef enum logic [1:0] {OP_S = 2'h0, OP_B = 2'h1, OP_R = 2'h2, OP_P = 2'h3} sps_op_e;
  typedef enum logic {HS_IDLE = 1'b0, HS_RUN = 1'b1} sps_hst_e;
endpackage
`default_nettype wire

// [rtl/sps_i2c_if.sv]
// two-wire bus joining the controller end and the device end
// assumes open drain: an enable pulls the line low, pull-ups otherwise
`default_nettype none
interface sps_i2c_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // ==========================================================
  // wired-and resolution of the two lines
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (input scl, input sda, output scl_m_o, output scl_m_oe,
                output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// [rtl/sps_i2c_dev.sv]
// device end: strap decode and two-wire slave with 16-bit addressing
// assumes a user register file answering reg_rdata for reg_addr at once
`default_nettype none
module sps_i2c_dev
  import sps_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  sps_i2c_if.dev bus,
  input wire logic [1:0] port_strap_high,
  input wire logic [1:0] port_strap_low,
  input wire logic eeprom_boot_pin,
  input wire logic chip_sleep_n,
  output logic spi_sel,
  output logic core_sleep,
  output logic [6:0] slave_addr,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic reload_req,
  input wire logic reload_done
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic [1:0] hi_a;
    logic [1:0] hi_b;
    logic [1:0] lo_a;
    logic [1:0] lo_b;
    logic [1:0] boot_s;
    logic [1:0] slp_s;
    sps_dst_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] idx;
    logic rw;
    logic sda_oe;
    logic [15:0] ra;
    logic [7:0] wd;
    logic wr;
    logic rd;
    logic reload;
  } sps_dev_s;

  localparam sps_dev_s DEV_RST = '0;

  sps_dev_s q;
  sps_dev_s n;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic spi_on;
  logic [6:0] my_addr;
  logic [7:0] rd_byte;

  // three-level strap pair to address lsbs, high counts three
  function automatic logic [2:0] strap_code(input logic [1:0] hi, input logic [1:0] lo);
    logic [2:0] h;
    h = 3'(hi);
    return 3'((h << 1) + h + 3'(lo));
  endfunction

  // ==========================================================
  // decode of synchronised lines
  assign rise = q.scl_s[1] && !q.scl_p;
  assign fall = !q.scl_s[1] && q.scl_p;
  assign start = q.scl_s[1] && q.scl_p && q.sda_p && !q.sda_s[1];
  assign stop = q.scl_s[1] && q.scl_p && !q.sda_p && q.sda_s[1];
  assign spi_on = (q.hi_b == LVL_HIGH) && (q.lo_b == LVL_HIGH);
  assign my_addr = {ADDR_FIXED, strap_code(q.hi_b, q.lo_b)};
  // self-clearing reload bit reads back its live state
  assign rd_byte = (q.ra == RELOAD_REG) ?
                   {reg_rdata[7:2], q.reload, reg_rdata[0]} : reg_rdata;

  // ==========================================================
  // next state
  always_comb begin
    n = q;
    n.wr = 1'b0;
    n.rd = 1'b0;
    // pins pass two flops before any logic reads them
    // short sync latency serves both bus rates
    n.scl_s = {q.scl_s[0], bus.scl};
    n.sda_s = {q.sda_s[0], bus.sda};
    n.scl_p = q.scl_s[1];
    n.sda_p = q.sda_s[1];
    n.hi_a = port_strap_high;
    n.hi_b = q.hi_a;
    n.lo_a = port_strap_low;
    n.lo_b = q.lo_a;
    n.boot_s = {q.boot_s[0], eeprom_boot_pin};
    n.slp_s = {q.slp_s[0], chip_sleep_n};
    // advance after each written or returned byte
    if (q.wr || q.rd) begin
      n.ra = q.ra + 16'h0001;
    end
    if (reload_done) begin
      n.reload = 1'b0;
    end
    // sleep does not touch this logic or stored values
    // start or stop overrides any partial byte
    if (start && !spi_on) begin
      n.st = DS_RX;
      n.cnt = 4'h0;
      n.idx = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop || spi_on) begin
      n.st = DS_IDLE;
      n.sda_oe = 1'b0;
    end else if (rise) begin
      unique case (q.st)
        DS_RX: begin
          // one bit per pulse, msb first
          n.sh = {q.sh[6:0], q.sda_s[1]};
          n.cnt = q.cnt + 4'h1;
        end
        DS_RACK: begin
          n.st = q.sda_s[1] ? DS_IDLE : DS_ACK;
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      // data moves only after a falling clock edge
      unique case (q.st)
        DS_RX: begin
          if (q.cnt == 4'h8) begin
            n.cnt = 4'h0;
            n.st = DS_ACK;
            n.sda_oe = 1'b1;
            unique case (q.idx)
              2'h0: begin
                // address byte match or stay off the bus
                if (q.sh[7:1] == my_addr) begin
                  n.rw = q.sh[0];
                  n.idx = 2'h1;
                end else begin
                  n.st = DS_IDLE;
                  n.sda_oe = 1'b0;
                end
              end
              2'h1: begin
                n.ra[15:8] = q.sh;
                n.idx = 2'h2;
              end
              2'h2: begin
                n.ra[7:0] = q.sh;
                n.idx = 2'h3;
              end
              2'h3: begin
                n.wd = q.sh;
                n.wr = 1'b1;
                // reload only with boot pin low, set beats clear
                if (q.ra == RELOAD_REG && q.sh[RELOAD_BIT] && !q.boot_s[1]) begin
                  n.reload = 1'b1;
                end
              end
            endcase
          end
        end
        DS_ACK: begin
          n.sda_oe = 1'b0;
          if (q.rw) begin
            // return the byte at the current address
            n.sh = rd_byte;
            n.sda_oe = !rd_byte[7];
            n.rd = 1'b1;
            n.cnt = 4'h0;
            n.st = DS_TX;
          end else begin
            n.st = DS_RX;
          end
        end
        DS_TX: begin
          if (q.cnt == 4'h7) begin
            n.sda_oe = 1'b0;
            n.st = DS_RACK;
          end else begin
            n.cnt = q.cnt + 4'h1;
            n.sh = {q.sh[6:0], 1'b0};
            n.sda_oe = !q.sh[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= DEV_RST;
    end else begin
      q <= n;
    end
  end

  // only the data line has a driver here
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = q.sda_oe;
  assign spi_sel = spi_on;
  assign core_sleep = !q.slp_s[1];
  assign slave_addr = my_addr;
  assign reg_addr = q.ra;
  assign reg_wdata = q.wd;
  assign reg_wr = q.wr;
  assign reg_rd = q.rd;
  assign reload_req = q.reload;
endmodule // sps_i2c_dev
`default_nettype wire

// [rtl/sps_fix_note.sv]
`default_nettype none
`default_nettype wire

// [dv/sps_i2c_monitor.sv]
// checker for the two-wire bus joining the host and device ends
// assumes one mclk domain and the interface's resolved scl and sda
`default_nettype none
module sps_i2c_monitor #(
  parameter int QTR = 6
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HI_MAX = 2 * QTR + 1;
  logic scl_q, sda_q, act_q, first_q, rd_q, miss_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] hi_q;
  logic rise, start, stop, slot9;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // frame tracking
  // edge and condition decode on the resolved lines
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign slot9 = rise && act_q && (bit_q == 4'h8);
  // lines idle high in reset so its release never looks like a start
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      act_q <= 1'b0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      miss_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      hi_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      hi_q <= scl ? hi_q + 8'h01 : 8'h00;
      if (start) begin
        act_q <= 1'b1;
        first_q <= 1'b1;
        rd_q <= 1'b0;
        miss_q <= 1'b0;
        bit_q <= 4'h0;
      end else if (stop) begin
        act_q <= 1'b0;
      end else if (rise && act_q) begin
        if (bit_q == 4'h8) begin
          bit_q <= 4'h0;
          first_q <= 1'b0;
          if (first_q) begin
            rd_q <= sh_q[0];
            miss_q <= sda;
          end
        end else begin
          sh_q <= {sh_q[6:0], sda};
          bit_q <= bit_q + 4'h1;
        end
      end
    end
  end
  // ==========================================================
  // assertions
  a_scl_host_only: assert property (!scl |-> scl_m_oe && !scl_m_o)
    else $error("clock line low without host drive");
  a_scl_high_len: assert property ($fell(scl) && act_q && !(first_q && bit_q == 4'h0)
    |-> hi_q >= QTR && hi_q <= HI_MAX)
    else $error("clock high period wrong");
  a_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("device data changed while clock high");
  a_no_drive_wr: assert property (rise && act_q && !rd_q && bit_q != 4'h8 |-> !sda_s_oe)
    else $error("device drove a data bit of a received byte");
  a_ack_data: assert property (slot9 && !first_q && !rd_q && !miss_q
    |-> sda_s_oe && !sda_s_o)
    else $error("device missed an acknowledge");
  a_host_acks_rd: assert property (slot9 && rd_q |-> !sda_s_oe)
    else $error("device drove the host acknowledge slot");
  a_upper_fixed: assert property (slot9 && first_q && sh_q[7:4] != 4'hB |-> !sda_s_oe)
    else $error("device answered a foreign address");
  a_miss_idle: assert property (act_q && miss_q |-> !sda_s_oe)
    else $error("device active after address mismatch");
  c_start: cover property (start && sda_m_oe && !sda_m_o);
  c_read_slot: cover property (slot9 && rd_q);
  c_miss_stop: cover property (miss_q && stop);
endmodule // sps_i2c_monitor
`default_nettype wire

// [dv/test_serial_port_select_i2c_slave.sv]
// self-checking bench: host end and device end joined over the interface
// assumes the host's axi4-lite slave and a comb register file at the device
`default_nettype none
module test_serial_port_select_i2c_slave
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, sys_rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv, seed;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, port_strap_high, port_strap_low;
  logic eeprom_boot_pin, chip_sleep_n, spi_sel, core_sleep, reg_wr, reg_rd;
  logic reload_req, reload_done;
  logic [6:0] slave_addr;
  logic [15:0] reg_addr, wr_a;
  logic [7:0] reg_wdata, reg_rdata, wr_d;
  int failures = 0;
  int checks = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  sps_i2c_if bus_if ();
  sps_i2c_host #(.QTR(6)) sps_i2c_host_inst (.mclk, .sys_rst, .bus(bus_if),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  sps_i2c_dev sps_i2c_dev_inst (.mclk, .sys_rst, .bus(bus_if), .port_strap_high,
    .port_strap_low, .eeprom_boot_pin, .chip_sleep_n, .spi_sel, .core_sleep,
    .slave_addr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reload_req,
    .reload_done);
  sps_i2c_monitor #(.QTR(6)) sps_i2c_monitor_inst (.mclk, .sys_rst,
    .scl_m_o(bus_if.scl_m_o), .scl_m_oe(bus_if.scl_m_oe), .sda_m_o(bus_if.sda_m_o),
    .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // register file contents as a fixed function of the address
  function automatic logic [7:0] rd_fn(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3C;
  endfunction
  assign reg_rdata = rd_fn(reg_addr);
  // record each register write the device issues
  always @(posedge mclk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_a <= reg_addr;
      wr_d <= reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // handshake sampled before the edge, payload held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge mclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (b !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge mclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid && s_axi_rready;
      rdv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (r !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // one bus transfer, then poll status until the host is idle
  task automatic i2c_op(input logic [6:0] dev, input logic rw, input logic [15:0] ra,
                        input logic [7:0] wd);
    logic [31:0] c;
    int n;
    c = 32'h0000_0000;
    c[CTRL_GO] = 1'b1;
    c[CTRL_RW] = rw;
    c[CTRL_DEV_LSB +: 7] = dev;
    axi_wr(HR_RADDR, {16'h0000, ra});
    axi_wr(HR_WDATA, {24'h000000, wd});
    axi_wr(HR_CTRL, c);
    n = 0;
    do begin
      axi_rd(HR_STAT);
      n++;
    end while (rdv[STAT_BUSY] !== 1'b0 && n < 4000);
    if (rdv[STAT_BUSY] !== 1'b0) begin
      failures++;
      $display("[FAIL] %0t busy never cleared", $time);
      give_verdict();
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and scenarios
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // longest run is well under this many cycles
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    logic [6:0] dev;
    logic [15:0] ra;
    logic [7:0] wd;
    int n;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {port_strap_high, port_strap_low, eeprom_boot_pin, reload_done} = '0;
    chip_sleep_n = 1'b1;
    seed = 32'h0001_063F;
    sys_rst = 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    axi_wr(8'h10, 32'h0000_0001);
    cmp(resp, RESP_SLVERR, "unmapped write");
    axi_rd(8'h10);
    cmp({resp, rdv[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
    port_strap_high <= LVL_HIGH;
    port_strap_low <= LVL_HIGH;
    repeat (6) @(posedge mclk);
    cmp(spi_sel, 1'b1, "spi select");
    for (int code = 0; code < 8; code++) begin
      seed = xs(seed);
      port_strap_high <= 2'(code / 3);
      port_strap_low <= 2'(code % 3);
      chip_sleep_n <= seed[0];
      repeat (6) @(posedge mclk);
      dev = {4'hB, code[2:0]};
      cmp(slave_addr, dev, "slave address");
      cmp(spi_sel, 1'b0, "i2c select");
      cmp(core_sleep, !seed[0], "sleep report");
      ra = {1'b1, seed[30:16]};
      wd = seed[7:0];
      n = wr_cnt;
      i2c_op(dev, 1'b0, ra, wd);
      cmp(rdv[STAT_NACK], 1'b0, "write acked");
      cmp({wr_a, wr_d}, {ra, wd}, "write landed");
      cmp(wr_cnt, n + 1, "one write");
      cmp(reg_addr, 16'(ra + 16'h0001), "address advanced");
      i2c_op(dev, 1'b1, ra, 8'h00);
      cmp(rdv[STAT_RD_LSB +: 8], rd_fn(ra), "read byte");
      cmp(rd_cnt, code + 1, "one byte read");
      i2c_op({4'hB, code[2:0] ^ 3'h1}, 1'b0, ra, wd);
      cmp(rdv[STAT_NACK], 1'b1, "foreign low bits");
      cmp(wr_cnt, n + 1, "no write on miss");
    end
    i2c_op(7'h38, 1'b0, 16'h0010, 8'h11);
    cmp(rdv[STAT_NACK], 1'b1, "foreign high bits");
    i2c_op(dev, 1'b0, RELOAD_REG, 8'h02);
    cmp(reload_req, 1'b1, "reload raised");
    @(posedge mclk);
    reload_done <= 1'b1;
    @(posedge mclk);
    reload_done <= 1'b0;
    repeat (2) @(posedge mclk);
    cmp(reload_req, 1'b0, "reload cleared");
    eeprom_boot_pin <= 1'b1;
    i2c_op(dev, 1'b0, RELOAD_REG, 8'h02);
    cmp(reload_req, 1'b0, "reload gated");
    give_verdict();
  end
endmodule // test_serial_port_select_i2c_slave
`default_nettype wire
